/* File: hw/rmd_defs.svh */
// Constants of the remote module diagnostics block.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef RMD_DEFS_SVH
`define RMD_DEFS_SVH
`define RMD_CLK_HZ 20000000
`define RMD_DISP_S 3
`define RMD_HOLD_S 10
`define RMD_FLASH_MS 250
`define RMD_NCH 8
`define RMD_OVL_POS 4
`define RMD_ERR_OVL 8'h04
`define RMD_ERR_DROP 8'h0F
`define RMD_OFS_STATUS 8'h00
`define RMD_OFS_ABORT 8'h04
`define RMD_OFS_FLAGS 8'h08
`define RMD_OFS_ACK 8'h0C
`define RMD_OFS_ERRNUM 8'h10
`define RMD_OFS_DEVTYPE 8'h14
`define RMD_OFS_GROUP 8'h18
`define RMD_OFS_CHAN 8'h1C
`define RMD_OFS_REMOTE 8'h20
`define RMD_RST_ABORT 16'h0000
`endif

/* File: hw/rmd_pkg.sv */
// Types of the remote module diagnostics block.
// Assumes the constants header is compiled alongside.
package rmd_pkg;
    // One diagnostic report arriving at the master
    typedef struct packed {
        logic [7:0] err_num;  // Error number
        logic [7:0] dev_type; // Device type code
        logic [7:0] group;    // Group number or module address
        logic [7:0] chan;     // Channel number
    } rmd_diag_t;
    // Test button sequence states, one-hot
    typedef enum logic [4:0] {
        RMD_IDLE = 5'h01,
        RMD_SEL  = 5'h02,
        RMD_DIAG = 5'h04,
        RMD_LAMP = 5'h08,
        RMD_DIL  = 5'h10
    } rmd_state_t;
endpackage : rmd_pkg

/* File: hw/rmd_top.sv */
// Remote module diagnostics and the matching master error bookkeeping.
// Assumes button and switch pins are asynchronous; all other inputs
// come from logic on sys_clk_i. Registers sit on a plain strobe port.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "rmd_defs.svh"

module rmd_top #(
    parameter int unsigned DISP_CYC = `RMD_DISP_S * `RMD_CLK_HZ,  // Display time
    parameter int unsigned HOLD_CYC = `RMD_HOLD_S * `RMD_CLK_HZ,  // Long press
    parameter int unsigned FLASH_CYC = `RMD_FLASH_MS * (`RMD_CLK_HZ / 1000) // Half blink
) (
    input wire logic sys_clk_i,              // System clock
    input wire logic sys_rst_i,              // Async reset, high
    input wire logic [7:0] reg_addr_i,       // Register byte address
    input wire logic [31:0] reg_wdata_i,     // Write data
    input wire logic reg_wr_i,               // Write strobe
    input wire logic reg_rd_i,               // Read strobe
    output logic [31:0] reg_rdata_o,         // Read data, next cycle
    input wire logic test_btn_i,             // Test button pin, high pressed
    input wire logic [7:0] dil_sw_i,         // Switch pins, bit n is switch n+1
    input wire logic comm_ok_i,              // Bus traffic with master running
    input wire logic [7:0] ch_ovl_i,         // Per-channel overload level
    input wire logic self_done_i,            // Self test finished
    input wire logic self_pass_i,            // Self test result
    output logic err_led_o,                  // Module error lamp
    output logic [7:0] leds_o,               // Module channel lamps
    output logic bus_en_o,                   // Module may join bus traffic
    output logic outputs_off_o,              // Force analog outputs off
    input wire logic diag_vld_i,             // Diagnostic report pulse
    input wire rmd_pkg::rmd_diag_t diag_i,   // Diagnostic report
    input wire logic drop_vld_i,             // Module dropped pulse
    input wire logic [7:0] drop_type_i,      // Dropped module type code
    input wire logic [7:0] drop_addr_i,      // Dropped module address
    input wire logic bus_proc_ok_i,          // Bus processor active
    input wire logic serial_ok_i,            // Master bus interfacing works
    input wire logic class2_err_i,           // Class 2 error present
    input wire logic dt_valid_i,             // Date and time valid
    input wire logic batt_ok_i,              // Battery present
    input wire logic [7:0] mod_count_i,      // Modules currently found
    input wire logic direct_ovl_i,           // Direct output overloaded
    output logic bus_act_led_o,              // Bus processor active lamp
    output logic bus_fault_indicator_o,      // Bus error lamp
    output logic remote_fault_indicator_o,   // Remote unit error lamp
    output logic serial_interface_fault_indicator_o, // Serial error lamp
    output logic light_err_led_o,            // Light error lamp
    output logic ovl_led_o,                  // Red overload lamp
    output logic prog_run_o,                 // Program and bus keep running
    output logic [15:0] status_o             // Master status word
);
    // Terminal counts, each cut to the width of the counter that meets it
    // The counter widths hold the full display, hold and blink times at 20 MHz
    localparam logic [25:0] DISP_W = 26'(DISP_CYC - 1);
    localparam logic [27:0] HOLD_W = 28'(HOLD_CYC - 1);
    localparam logic [22:0] FLASH_W = 23'(FLASH_CYC - 1);
    localparam logic [2:0] LAST_CH = 3'(`RMD_NCH - 1);

    // Pin synchronisers, three stages
    logic [8:0] s1_ff, s2_ff, s3_ff;  // Button and switches
    logic [8:0] filt_ff;              // Filtered pin levels
    logic btn_prev_ff;                // Button one cycle ago

    // Remote module state
    rmd_pkg::rmd_state_t st_ff, nxt_st;  // Test sequence state
    logic [2:0] ch_ff, nxt_ch;           // Selected channel
    logic [25:0] disp_ff, nxt_disp;      // Display timer
    logic [27:0] hold_ff;                // Press duration
    logic [22:0] flash_cnt_ff;           // Blink divider
    logic flash_ff;                      // Blink phase
    logic [7:0] store_ff;                // Stored channel errors
    logic self_fail_ff;                  // Self test failed
    logic self_seen_ff;                  // Self test finished

    // Master state
    logic sum_ff, warn_ff, light_ff;     // Error flags
    rmd_pkg::rmd_diag_t words_ff;        // Error words
    logic [15:0] abort_ff;               // Abort-on-light-error constant
    logic [7:0] peak_ff;                 // Peak module count
    logic [31:0] rdata_ff;               // Read data

    // Decoded events
    // Button edges are taken from the filtered level, so bounce is already gone
    wire btn = filt_ff[8];
    wire [7:0] dil = filt_ff[7:0];
    wire press = btn & ~btn_prev_ff;
    wire release_ev = ~btn & btn_prev_ff;
    wire disp_end = (disp_ff == DISP_W);
    wire long_clr = btn & (hold_ff == HOLD_W);
    // Register strobes that change state
    wire wr_ack = reg_wr_i & (reg_addr_i == `RMD_OFS_ACK) & reg_wdata_i[0];
    wire wr_abort = reg_wr_i & (reg_addr_i == `RMD_OFS_ABORT);
    wire rem_clr = long_clr | wr_ack;
    // Bus presence of the module and a summary of its stored faults
    wire on_bus = self_seen_ff & ~self_fail_ff;
    wire comm_up = comm_ok_i & on_bus;
    wire any_err = |store_ff;

    // Synchroniser chain; a level counts once stages two and three agree
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_ff <= 9'h000;
            s2_ff <= 9'h000;
            s3_ff <= 9'h000;
        end else begin
            s1_ff <= {test_btn_i, dil_sw_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Per-bit filter on agreeing stages; a bit whose stages differ keeps its level
    wire [8:0] nxt_filt;  // Filter next value
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_filt
            // A level still settling in the chain is not taken yet
            assign nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : filt_ff[gi];
        end
    endgenerate

    // Filtered pin levels, written by one process only
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_ff <= 9'h000;
        end else begin
            filt_ff <= nxt_filt;
        end
    end

    // Button edge history
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            btn_prev_ff <= 1'b0;
        end else begin
            btn_prev_ff <= btn;
        end
    end

    // Press duration, saturates so the clear fires once per hold
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_ff <= 28'h0000000;
        end else if (!btn) begin
            hold_ff <= 28'h0000000;
        end else if (hold_ff <= HOLD_W) begin
            hold_ff <= hold_ff + 28'h0000001;
        end
    end

    // Blink divider for selection and bus-down flashing
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flash_cnt_ff <= 23'h000000;
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff == FLASH_W) begin
            flash_cnt_ff <= 23'h000000;
            flash_ff <= ~flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 23'h000001;
        end
    end

    // Test button sequence, next state
    always_comb begin
        nxt_st = st_ff;
        nxt_ch = ch_ff;
        nxt_disp = 26'h0000000;
        case (st_ff)
            rmd_pkg::RMD_IDLE: begin
                if (press) begin
                    nxt_st = rmd_pkg::RMD_SEL;
                    nxt_ch = 3'h0;
                end
            end
            rmd_pkg::RMD_SEL: begin
                if (release_ev) begin
                    nxt_st = rmd_pkg::RMD_DIAG;
                end
            end
            rmd_pkg::RMD_DIAG: begin
                // A press outranks the display timeout in the same cycle
                nxt_disp = disp_ff + 26'h0000001;
                if (press && ch_ff == LAST_CH) begin
                    nxt_st = rmd_pkg::RMD_LAMP;
                end else if (press) begin
                    nxt_st = rmd_pkg::RMD_SEL;
                    nxt_ch = ch_ff + 3'h1;
                end else if (disp_end) begin
                    nxt_st = rmd_pkg::RMD_IDLE;
                end
            end
            rmd_pkg::RMD_LAMP: begin
                if (release_ev) begin
                    nxt_st = rmd_pkg::RMD_DIL;
                end
            end
            rmd_pkg::RMD_DIL: begin
                nxt_disp = disp_ff + 26'h0000001;
                if (press) begin
                    nxt_st = rmd_pkg::RMD_SEL;
                    nxt_ch = 3'h0;
                    nxt_disp = 26'h0000000;
                end else if (disp_end) begin
                    nxt_st = rmd_pkg::RMD_IDLE;
                end
            end
            default: begin
                nxt_st = rmd_pkg::RMD_IDLE;
                nxt_ch = 3'h0;
            end
        endcase
        if (nxt_st != st_ff) begin
            nxt_disp = 26'h0000000;  // Each display starts its own window
        end
    end

    // Test button sequence registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= rmd_pkg::RMD_IDLE;
            ch_ff <= 3'h0;
            disp_ff <= 26'h0000000;
        end else begin
            st_ff <= nxt_st;
            ch_ff <= nxt_ch;
            disp_ff <= nxt_disp;
        end
    end

    // Stored channel errors; a new fault beats a clear in the same cycle
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            store_ff <= 8'h00;
        end else begin
            store_ff <= (store_ff & ~{8{rem_clr}}) | ch_ovl_i;
        end
    end

    // Self test result, caught when the test reports done
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            self_seen_ff <= 1'b0;
            self_fail_ff <= 1'b0;
        end else if (self_done_i && !self_seen_ff) begin
            self_seen_ff <= 1'b1;
            self_fail_ff <= ~self_pass_i;
        end
    end

    // Channel lamps by sequence state
    wire [7:0] sel_pat = 8'(flash_ff) << ch_ff;
    wire [7:0] diag_pat = 8'(store_ff[ch_ff]) << `RMD_OVL_POS;
    wire [7:0] lamp_pat = (st_ff == rmd_pkg::RMD_SEL) ? sel_pat :
                          (st_ff == rmd_pkg::RMD_DIAG) ? diag_pat :
                          (st_ff == rmd_pkg::RMD_LAMP) ? 8'hFF :
                          (st_ff == rmd_pkg::RMD_DIL) ? dil :
                          8'h00;

    // Module error lamp: self fail, then peripheral, then bus down
    // Self fail outranks all so a dead module never looks healthy
    wire err_lamp = self_fail_ff ? 1'b1 :
                    any_err ? 1'b1 :
                    !comm_up ? flash_ff :
                    1'b0;

    // Master flags; a new report beats an acknowledge in the same cycle
    // One acknowledge write clears all three flags together
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sum_ff <= 1'b0;
            warn_ff <= 1'b0;
            light_ff <= 1'b0;
        end else begin
            sum_ff <= (sum_ff & ~wr_ack) | diag_vld_i | drop_vld_i;
            warn_ff <= (warn_ff & ~wr_ack) | diag_vld_i;
            light_ff <= (light_ff & ~wr_ack) | drop_vld_i;
        end
    end

    // Error words, overwritten by each new error; a drop beats a report in the same cycle
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            words_ff <= '0;
        end else if (drop_vld_i) begin
            words_ff <= {`RMD_ERR_DROP, drop_type_i, drop_addr_i, 8'h00};
        end else if (diag_vld_i) begin
            words_ff <= diag_i;
        end
    end

    // Abort constant and peak module count
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            abort_ff <= `RMD_RST_ABORT;
            peak_ff <= 8'h00;
        end else begin
            if (wr_abort) begin
                abort_ff <= reg_wdata_i[15:0];
            end
            if (mod_count_i > peak_ff) begin
                peak_ff <= mod_count_i;
            end
        end
    end

    // Status word layout
    // Bit 1 stays zero; it only carries meaning on a slave unit
    wire [15:0] status = {peak_ff, 4'h0, batt_ok_i, dt_valid_i, 1'b0, ~class2_err_i};

    // Read data mux
    // Unmapped addresses read as zero
    wire [31:0] rd_mux =
        (reg_addr_i == `RMD_OFS_STATUS) ? {16'h0000, status} :
        (reg_addr_i == `RMD_OFS_ABORT) ? {16'h0000, abort_ff} :
        (reg_addr_i == `RMD_OFS_FLAGS) ? {29'h00000000, light_ff, warn_ff, sum_ff} :
        (reg_addr_i == `RMD_OFS_ERRNUM) ? {24'h000000, words_ff.err_num} :
        (reg_addr_i == `RMD_OFS_DEVTYPE) ? {24'h000000, words_ff.dev_type} :
        (reg_addr_i == `RMD_OFS_GROUP) ? {24'h000000, words_ff.group} :
        (reg_addr_i == `RMD_OFS_CHAN) ? {24'h000000, words_ff.chan} :
        (reg_addr_i == `RMD_OFS_REMOTE) ? {24'h000000, store_ff} :
        32'h00000000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= reg_rd_i ? rd_mux : 32'h00000000;
        end
    end

    // Outputs
    // Master lamps follow its flags; plain status inputs pass straight through, except serial_ok_i and class2_err_i, which are inverted
    assign reg_rdata_o = rdata_ff;
    assign leds_o = lamp_pat;
    assign err_led_o = err_lamp;
    assign bus_en_o = on_bus;
    assign outputs_off_o = ~comm_up;
    assign bus_act_led_o = bus_proc_ok_i;
    assign bus_fault_indicator_o = light_ff;
    assign remote_fault_indicator_o = warn_ff;
    assign serial_interface_fault_indicator_o = ~serial_ok_i;
    assign light_err_led_o = light_ff;
    assign ovl_led_o = direct_ovl_i;
    assign prog_run_o = ~(light_ff & (abort_ff != 16'h0000));
    assign status_o = status;
endmodule : rmd_top

/* File: bench/rmd_assertions.sv */
// Checker for the diagnostics block, bound to its top module.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ns
module rmd_checker (
    input wire logic sys_clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic direct_ovl_i, // Direct output overload
    input wire logic serial_ok_i, // Master link fine
    input wire logic bus_proc_ok_i, // Bus processor active
    input wire logic class2_err_i, // Class 2 error
    input wire logic dt_valid_i, // Date valid
    input wire logic batt_ok_i, // Battery present
    input wire logic comm_ok_i, // Bus traffic fine
    input wire logic diag_vld_i, // Report pulse
    input wire logic drop_vld_i, // Drop pulse
    input wire logic ovl_led_o, // Overload lamp
    input wire logic serial_interface_fault_indicator_o, // Serial lamp
    input wire logic bus_act_led_o, // Bus active lamp
    input wire logic bus_fault_indicator_o, // Bus error lamp
    input wire logic remote_fault_indicator_o, // Remote error lamp
    input wire logic light_err_led_o, // Light error lamp
    input wire logic prog_run_o, // Program running
    input wire logic outputs_off_o, // Analog outputs forced off
    input wire logic [15:0] status_o // Status word
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Steps of a module drop
    sequence s_drop;
        drop_vld_i;
    endsequence
    sequence s_light_on;
        light_err_led_o && bus_fault_indicator_o;
    endsequence
    a_ovl_lamp: assert property (ovl_led_o == direct_ovl_i)
        else $error("overload lamp mismatch");
    a_master_lamps: assert property (serial_interface_fault_indicator_o == !serial_ok_i &&
        bus_act_led_o == bus_proc_ok_i) else $error("master lamp mismatch");
    a_drop_light: assert property (s_drop |=> s_light_on)
        else $error("drop did not raise light error");
    a_diag_warn: assert property (diag_vld_i |=> remote_fault_indicator_o)
        else $error("report did not raise warning");
    a_status_bits: assert property (status_o[7:0] == {4'h0, batt_ok_i, dt_valid_i, 1'b0, !class2_err_i})
        else $error("status low byte mismatch");
    a_peak_kept: assert property (status_o[15:8] >= $past(status_o[15:8]))
        else $error("peak count fell");
    a_lost_off: assert property (!comm_ok_i |-> outputs_off_o)
        else $error("outputs not forced off");
    a_run_kept: assert property (!light_err_led_o |-> prog_run_o)
        else $error("program stopped without light error");
endmodule : rmd_checker
bind rmd_top rmd_checker i_chk (.*);

/* File: bench/rmd_master_model.sv */
// Master side model that sends diagnostic and drop reports.
// Assumes the bench calls its tasks right after a clock edge.
`timescale 1ns/1ns
module rmd_master_model (
    input wire logic clk_i, // Clock
    output logic diag_vld_o, // Report pulse
    output rmd_pkg::rmd_diag_t diag_o, // Report fields
    output logic drop_vld_o, // Drop pulse
    output logic [7:0] drop_type_o, // Dropped type
    output logic [7:0] drop_addr_o // Dropped address
);
    initial begin
        diag_vld_o = 1'b0;
        drop_vld_o = 1'b0;
        diag_o = '0;
        drop_type_o = 8'h00;
        drop_addr_o = 8'h00;
    end
    // One report cycle; fields scrambled once released
    task automatic send_diag(input rmd_pkg::rmd_diag_t d);
        @(posedge clk_i);
        diag_vld_o <= 1'b1;
        diag_o <= d;
        @(posedge clk_i);
        diag_vld_o <= 1'b0;
        diag_o <= ~d;
    endtask : send_diag
    // One drop cycle
    task automatic send_drop(input logic [7:0] t, input logic [7:0] a);
        @(posedge clk_i);
        drop_vld_o <= 1'b1;
        drop_type_o <= t;
        drop_addr_o <= a;
        @(posedge clk_i);
        drop_vld_o <= 1'b0;
        drop_type_o <= ~t;
        drop_addr_o <= ~a;
    endtask : send_drop
endmodule : rmd_master_model

/* File: bench/rmd_top_tb.sv */
// Self-checking bench for the diagnostics block.
// Assumes the bound checker and the master model beside the design.
`timescale 1ns/1ns
module rmd_top_tb;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, test_btn_i = 1'b0;
    logic comm_ok_i = 1'b1, self_done_i = 1'b1, self_pass_i = 1'b1, bus_proc_ok_i = 1'b1;
    logic serial_ok_i = 1'b1, direct_ovl_i = 1'b0, class2_err_i, dt_valid_i, batt_ok_i;
    logic [7:0] reg_addr_i = 8'h00, ch_ovl_i = 8'h00, dil_sw_i, mod_count_i, drop_type_i, drop_addr_i, leds_o;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic diag_vld_i, drop_vld_i, err_led_o, bus_en_o, outputs_off_o, bus_act_led_o, ovl_led_o, prog_run_o;
    logic bus_fault_indicator_o, remote_fault_indicator_o, serial_interface_fault_indicator_o, light_err_led_o;
    logic [15:0] status_o, st;
    rmd_pkg::rmd_diag_t diag_i;
    int seed = 85;
    int fail_count = 0;
    int check_count = 0;
    int i;
    logic [39:0] exp_q[$]; // Address and expected read data
    logic rd_d = 1'b0;
    logic [1:0] seen;
    logic [7:0] codes [5] = '{8'h04, 8'h09, 8'h0A, 8'h04, 8'h04};
    logic [7:0] types [5] = '{8'h04, 8'h01, 8'h05, 8'h00, 8'h02};
    rmd_top #(.DISP_CYC(20), .HOLD_CYC(50), .FLASH_CYC(4)) i_dut (.*);
    rmd_master_model i_mst (.clk_i(sys_clk_i), .diag_vld_o(diag_vld_i), .diag_o(diag_i),
        .drop_vld_o(drop_vld_i), .drop_type_o(drop_type_i), .drop_addr_o(drop_addr_i));
    always #25 sys_clk_i = ~sys_clk_i;
    // Compare and count
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    // Bus write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // Bus read; expectation noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back({a, e});
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    // Button level, then time for the pin filter
    task automatic btn(input logic l);
        @(posedge sys_clk_i);
        test_btn_i <= l;
        tick(8);
    endtask : btn
    // Read data monitor
    always @(posedge sys_clk_i) begin
        if (rd_d) begin
            chk($sformatf("reg %h", exp_q[0][39:32]), reg_rdata_o, exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
        rd_d <= reg_rd_i;
    end
    // Random master levels behind the lamps
    always @(posedge sys_clk_i) begin
        direct_ovl_i <= 1'($random(seed));
        serial_ok_i <= 1'($random(seed));
        bus_proc_ok_i <= 1'($random(seed));
    end
    initial begin
        #(3000 * 50);
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        dil_sw_i = 8'($random(seed));
        mod_count_i = 8'($random(seed));
        {class2_err_i, dt_valid_i, batt_ok_i} = 3'($random(seed));
        tick(4);
        sys_rst_i <= 1'b0;
        tick(4);
        chk("bus_en", 32'(bus_en_o), 32'h1);
        st = {mod_count_i, 4'h0, batt_ok_i, dt_valid_i, 1'b0, ~class2_err_i};
        rd(8'h00, {16'h0, st});
        rd(8'h3C, 32'h0);
        st = 16'($random(seed)) | 16'h1;
        wr(8'h04, {16'h0, st});
        rd(8'h04, {16'h0, st});
        for (i = 0; i < 5; i++) begin
            i_mst.send_diag({codes[i], types[i], 8'(i), 8'h03});
            rd(8'h10, {24'h0, codes[i]});
            rd(8'h14, {24'h0, types[i]});
        end
        rd(8'h08, 32'h3);
        rd(8'h1C, 32'h3);
        i_mst.send_drop(8'h05, 8'h03);
        tick(1);
        chk("prog_run", 32'(prog_run_o), 32'h0);
        chk("bus_fault", 32'(bus_fault_indicator_o), 32'h1);
        chk("remote_fault", 32'(remote_fault_indicator_o), 32'h1);
        rd(8'h08, 32'h7);
        rd(8'h10, 32'hF);
        rd(8'h18, 32'h3);
        wr(8'h04, 32'h0);
        tick(1);
        chk("prog_run", 32'(prog_run_o), 32'h1);
        wr(8'h0C, 32'h1);
        rd(8'h08, 32'h0);
        chk("light", 32'(light_err_led_o), 32'h0);
        chk("bus_fault", 32'(bus_fault_indicator_o), 32'h0);
        chk("remote_fault", 32'(remote_fault_indicator_o), 32'h0);
        rd(8'h10, 32'hF);
        ch_ovl_i <= 8'h04;
        tick(3);
        chk("err_led", 32'(err_led_o), 32'h1);
        wr(8'h0C, 32'h1);
        rd(8'h20, 32'h4);
        ch_ovl_i <= 8'h00;
        for (i = 0; i < 8; i++) begin
            btn(1'b1);
            chk("sel", 32'(leds_o & ~(8'h01 << i)), 32'h0);
            btn(1'b0);
            chk("diag", 32'(leds_o), (i == 2) ? 32'h10 : 32'h0);
        end
        btn(1'b1);
        chk("lamp", 32'(leds_o), 32'hFF);
        btn(1'b0);
        chk("dil", 32'(leds_o), 32'(dil_sw_i));
        btn(1'b1);
        chk("sel0", 32'(leds_o & 8'hFE), 32'h0);
        btn(1'b0);
        tick(25);
        chk("idle", 32'(leds_o), 32'h0);
        rd(8'h20, 32'h4);
        btn(1'b1);
        tick(70);
        btn(1'b0);
        tick(25);
        rd(8'h20, 32'h0);
        chk("err_led", 32'(err_led_o), 32'h0);
        comm_ok_i <= 1'b0;
        seen = 2'b00;
        repeat (12) begin
            @(posedge sys_clk_i);
            seen[err_led_o] = 1'b1;
        end
        chk("flash", 32'(seen), 32'h3);
        chk("outputs_off", 32'(outputs_off_o), 32'h1);
        comm_ok_i <= 1'b1;
        tick(3);
        chk("outputs_on", 32'(outputs_off_o), 32'h0);
        // Power cycle with a failing self test: lamp on, module stays off the bus
        self_pass_i <= 1'b0;
        sys_rst_i <= 1'b1;
        tick(4);
        sys_rst_i <= 1'b0;
        tick(4);
        chk("bus_en", 32'(bus_en_o), 32'h0);
        chk("err_led", 32'(err_led_o), 32'h1);
        chk("outputs_off", 32'(outputs_off_o), 32'h1);
        chk("queue", exp_q.size(), 32'h0);
        stop_test();
    end
endmodule : rmd_top_tb
